// ---- shared/dfrs_pkg.sv ----
// Purpose: Constants for the drive frequency reference select block
// Assumes: 200 MHz pclk, frequencies in 0.01 Hz units, 12-bit samples
// Notes: Register byte offsets on a 32-bit APB word map
package dfrs_pkg;
	// Register byte offsets
	localparam logic [7:0] A_CFG = 8'h00;
	localparam logic [7:0] A_LOWER = 8'h04;
	localparam logic [7:0] A_UPPER = 8'h08;
	localparam logic [7:0] A_GAIN = 8'h0c;
	localparam logic [7:0] A_FILT = 8'h10;
	localparam logic [7:0] A_MAIN = 8'h14;
	localparam logic [7:0] A_LIMIT = 8'h18;
	localparam logic [7:0] A_STATUS = 8'h1c;
	localparam logic [7:0] A_PRESET = 8'h20;
	localparam logic [7:0] A_PRESET_END = 8'h38;
	// Configuration field positions
	localparam int CFG_TYPE = 0;
	localparam int CFG_LDIR = 3;
	localparam int CFG_UDIR = 4;
	localparam int CFG_NEGREV = 5;
	localparam int CFG_RETAIN = 6;
	localparam int CFG_STEP = 7;
	localparam int CFG_MODE = 8;
	localparam int CFG_SRC = 11;
	localparam int CFG_ASSIGN = 12;
	localparam int CFG_W = 13;
	// Analog input types
	typedef enum logic [2:0] {
		IN_V10 = 3'b000,
		IN_V5 = 3'b001,
		IN_I20 = 3'b010,
		IN_I4 = 3'b011,
		IN_STACK = 3'b100
	} dfrs_in_t;
	// Speed program modes
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_FOUR = 3'h1;
	localparam logic [2:0] MODE_MULTI = 3'h2;
	localparam logic [2:0] MODE_MAX = 3'h5;
	// Limits and reset values
	localparam logic [15:0] LOWER_MAX = 16'h9c40;
	localparam logic [15:0] UPPER_MAX = 16'hea60;
	localparam logic [15:0] UPPER_RST = 16'h1388;
	localparam logic [15:0] STACK_FULL = 16'h1388;
	localparam logic [15:0] MAIN_RST = 16'h0000;
	localparam logic [9:0] GAIN_MAX = 10'h3e8;
	localparam logic [5:0] FILT_MAX = 6'h32;
	localparam logic [5:0] FILT_RST = 6'h14;
	localparam logic [15:0] STEP_COARSE = 16'h000a;
	localparam logic [15:0] STEP_FINE = 16'h0001;
	localparam logic [11:0] ADC_FULL = 12'hfff;
	localparam logic [11:0] ADC_HALF = 12'h7ff;
	localparam logic [11:0] ADC_4MA = 12'h333;
	localparam logic [39:0] METER_DEN = 40'h0003938700;
	localparam logic [15:0] PRESET_RST [7] = '{16'h05dc, 16'h07d0, 16'h09c4,
		16'h0bb8, 16'h0dac, 16'h0fa0, 16'h0032};
	// Filter update time
	localparam int CLK_NS = 5;
	localparam int FILT_TICK_NS = 1000;
	localparam int FILT_TICK_CYC = FILT_TICK_NS / CLK_NS;
endpackage

// ---- src/dfrs_top.sv ----
// Purpose: Frequency command from analog curve, up/down keys and presets
// Assumes: APB slave, zero wait state, samples arrive on pclk
// Notes: Functional notes follow
`timescale 1ns/1ps
`default_nettype none
module dfrs_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter samples on pclk
	input wire logic [11:0] volt_sample,
	input wire logic [11:0] curr_sample,
	// Terminal pins, asynchronous
	input wire logic fwd_rev_pin,
	input wire logic run_pin,
	input wire logic up_key_pin,
	input wire logic down_key_pin,
	input wire logic [2:0] speed_sel_pin,
	input wire logic ext_dir_pin,
	input wire logic [1:0] ext_ramp_pin,
	// Command outputs
	output logic [15:0] freq_cmd,
	output logic dir_reverse,
	output logic [1:0] ramp_sel,
	output logic ramp_external,
	output logic [11:0] meter_out,
	output logic type_invalid
);
	// Software registers
	logic [dfrs_pkg::CFG_W-1:0] cfg;
	logic [15:0] lower_point_frequency, upper_point_frequency;
	logic [9:0] meter_output_gain;
	logic [5:0] analog_filter_constant;
	logic [15:0] main_frequency_setpoint, lower_limit;
	logic [15:0] preset_frequency [7];
	// Config fields
	logic [2:0] analog_input_type, speed_program_mode;
	logic lower_point_bias_dir, upper_point_bias_dir, negative_bias_reverse_enable;
	logic updown_change_retain, updown_step_size, main_frequency_source, sel_assigned;
	assign analog_input_type = cfg[dfrs_pkg::CFG_TYPE +: 3];
	assign lower_point_bias_dir = cfg[dfrs_pkg::CFG_LDIR];
	assign upper_point_bias_dir = cfg[dfrs_pkg::CFG_UDIR];
	assign negative_bias_reverse_enable = cfg[dfrs_pkg::CFG_NEGREV];
	assign updown_change_retain = cfg[dfrs_pkg::CFG_RETAIN];
	assign updown_step_size = cfg[dfrs_pkg::CFG_STEP];
	assign speed_program_mode = cfg[dfrs_pkg::CFG_MODE +: 3];
	assign main_frequency_source = cfg[dfrs_pkg::CFG_SRC];
	assign sel_assigned = cfg[dfrs_pkg::CFG_ASSIGN];

	// Pin synchroniser, two stages then an edge history stage
	logic [9:0] pin_raw, sync1, sync2, sync3;
	assign pin_raw = {ext_ramp_pin, ext_dir_pin, speed_sel_pin, down_key_pin,
		up_key_pin, run_pin, fwd_rev_pin};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	logic fwd_rev, up_edge, down_edge, run_fall;
	assign fwd_rev = sync2[0];
	assign run_fall = sync3[1] & ~sync2[1];
	assign up_edge = sync2[2] & ~sync3[2];
	assign down_edge = sync2[3] & ~sync3[3];

	// APB handshake, write strobe at the access edge
	logic wr_en, hit;
	logic [2:0] pidx;
	assign wr_en = psel & penable & pready & pwrite;
	assign pidx = 3'((paddr - dfrs_pkg::A_PRESET) >> 2);
	assign hit = (paddr <= dfrs_pkg::A_PRESET_END) && (paddr[1:0] == 2'b00);

	// Register next values, writes clamp to legal ranges
	logic [dfrs_pkg::CFG_W-1:0] next_cfg;
	logic [15:0] next_lower, next_upper, next_main, next_limit;
	logic [9:0] next_gain;
	logic [5:0] next_filt;
	logic [15:0] next_preset [7];
	always_comb begin
		next_cfg = cfg;
		next_lower = lower_point_frequency;
		next_upper = upper_point_frequency;
		next_gain = meter_output_gain;
		next_filt = analog_filter_constant;
		next_main = main_frequency_setpoint;
		next_limit = lower_limit;
		next_preset = preset_frequency;
		if (wr_en) begin
			unique case (paddr)
				dfrs_pkg::A_CFG: begin
					next_cfg = pwdata[dfrs_pkg::CFG_W-1:0];
					if (pwdata[dfrs_pkg::CFG_MODE +: 3] > dfrs_pkg::MODE_MAX)
						next_cfg[dfrs_pkg::CFG_MODE +: 3] = dfrs_pkg::MODE_MAX;
				end
				dfrs_pkg::A_LOWER: next_lower = (pwdata[15:0] > dfrs_pkg::LOWER_MAX) ?
					dfrs_pkg::LOWER_MAX : pwdata[15:0];
				dfrs_pkg::A_UPPER: next_upper = (pwdata[15:0] > dfrs_pkg::UPPER_MAX) ?
					dfrs_pkg::UPPER_MAX : pwdata[15:0];
				dfrs_pkg::A_GAIN: next_gain = (pwdata[9:0] > dfrs_pkg::GAIN_MAX) ?
					dfrs_pkg::GAIN_MAX : pwdata[9:0];
				dfrs_pkg::A_FILT: next_filt = (pwdata[5:0] > dfrs_pkg::FILT_MAX) ?
					dfrs_pkg::FILT_MAX : pwdata[5:0];
				dfrs_pkg::A_MAIN: next_main = (pwdata[15:0] > dfrs_pkg::UPPER_MAX) ?
					dfrs_pkg::UPPER_MAX : pwdata[15:0];
				dfrs_pkg::A_LIMIT: next_limit = (pwdata[15:0] > dfrs_pkg::UPPER_MAX) ?
					dfrs_pkg::UPPER_MAX : pwdata[15:0];
				default: begin
					// Presets, status is read only
					if (hit && paddr >= dfrs_pkg::A_PRESET)
						next_preset[pidx] = (pwdata[15:0] > dfrs_pkg::LOWER_MAX) ?
							dfrs_pkg::LOWER_MAX : pwdata[15:0];
				end
			endcase
		end
	end
	// bias and all control bits reset to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= '0;
			lower_point_frequency <= '0;
			upper_point_frequency <= dfrs_pkg::UPPER_RST;
			meter_output_gain <= dfrs_pkg::GAIN_MAX;
			analog_filter_constant <= dfrs_pkg::FILT_RST;
			main_frequency_setpoint <= dfrs_pkg::MAIN_RST;
			lower_limit <= '0;
			preset_frequency <= dfrs_pkg::PRESET_RST;
		end else begin
			cfg <= next_cfg;
			lower_point_frequency <= next_lower;
			upper_point_frequency <= next_upper;
			meter_output_gain <= next_gain;
			analog_filter_constant <= next_filt;
			main_frequency_setpoint <= next_main;
			lower_limit <= next_limit;
			preset_frequency <= next_preset;
		end
	end

	// Filter tick divider and per-constant pacing
	logic [7:0] tick_cnt, next_tick_cnt;
	logic [5:0] pace, next_pace;
	logic step_en;
	always_comb begin
		next_tick_cnt = (tick_cnt == 8'(dfrs_pkg::FILT_TICK_CYC - 1)) ? '0 : tick_cnt + 8'h01;
		next_pace = pace;
		step_en = 1'b0;
		if (tick_cnt == '0) begin
			step_en = (pace >= analog_filter_constant);
			next_pace = step_en ? '0 : pace + 6'h01;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= '0;
			pace <= '0;
		end else begin
			tick_cnt <= next_tick_cnt;
			pace <= next_pace;
		end
	end

	// one low-pass per channel, moves one eighth per paced step
	logic [11:0] filt [2];
	logic [11:0] raw [2];
	assign raw[0] = volt_sample;
	assign raw[1] = curr_sample;
	for (genvar c = 0; c < 2; c++) begin : g_filt
		logic [11:0] next_f;
		logic signed [12:0] diff, delta;
		always_comb begin
			diff = $signed({1'b0, raw[c]}) - $signed({1'b0, filt[c]});
			delta = diff >>> 3;
			// Creep the last few codes so the output settles exactly
			if (delta == '0 && diff != '0)
				delta = diff[12] ? -13'sd1 : 13'sd1;
			next_f = filt[c];
			if (analog_filter_constant == '0)
				next_f = raw[c];
			else if (step_en)
				next_f = 12'($signed({1'b0, filt[c]}) + delta);
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				filt[c] <= '0;
			else
				filt[c] <= next_f;
		end
	end

	// Analog curve: normalise, map, then apply bias sign
	logic [11:0] x;
	logic [14:0] i4_tmp;
	logic signed [31:0] lp, hp, curve;
	logic [25:0] stack_sum;
	logic [15:0] an_freq;
	logic an_rev, in_bad;
	always_comb begin
		i4_tmp = 15'((filt[1] - dfrs_pkg::ADC_4MA) * 15'd5) >> 2;
		lp = lower_point_bias_dir ? -$signed({16'h0, lower_point_frequency})
			: $signed({16'h0, lower_point_frequency});
		hp = upper_point_bias_dir ? -$signed({16'h0, upper_point_frequency})
			: $signed({16'h0, upper_point_frequency});
		in_bad = 1'b0;
		unique case (analog_input_type)
			dfrs_pkg::IN_V10: x = filt[0];
			dfrs_pkg::IN_V5: x = (filt[0] >= dfrs_pkg::ADC_HALF) ? dfrs_pkg::ADC_FULL
				: {filt[0][10:0], 1'b0};
			dfrs_pkg::IN_I20: x = filt[1];
			dfrs_pkg::IN_I4: x = (filt[1] <= dfrs_pkg::ADC_4MA) ? '0
				: (i4_tmp > 15'(dfrs_pkg::ADC_FULL)) ? dfrs_pkg::ADC_FULL : i4_tmp[11:0];
			dfrs_pkg::IN_STACK: x = '0;
			default: begin
				x = '0;
				in_bad = 1'b1;
			end
		endcase
		curve = lp + ((hp - lp) * $signed({20'h0, x})) / $signed({20'h0, dfrs_pkg::ADC_FULL});
		stack_sum = ({14'h0, filt[0]} + {14'h0, filt[1]}) * 26'(dfrs_pkg::STACK_FULL)
			/ (26'(dfrs_pkg::ADC_FULL) << 1);
		an_rev = 1'b0;
		an_freq = '0;
		if (in_bad)
			an_freq = '0;
		else if (analog_input_type == dfrs_pkg::IN_STACK)
			an_freq = stack_sum[15:0];
		// negative bias only reverses when enabled
		else if (curve < 0) begin
			an_rev = negative_bias_reverse_enable;
			an_freq = negative_bias_reverse_enable ? 16'(-curve) : '0;
		end else
			an_freq = curve[15:0];
	end

	// Up/down working frequency
	logic [15:0] ud_freq, next_ud, step;
	logic [16:0] ud_up;
	always_comb begin
		step = updown_step_size ? dfrs_pkg::STEP_FINE : dfrs_pkg::STEP_COARSE;
		ud_up = {1'b0, ud_freq} + {1'b0, step};
		next_ud = ud_freq;
		if (wr_en && paddr == dfrs_pkg::A_MAIN)
			next_ud = next_main;
		// discard change at stop unless retained
		else if (run_fall && !updown_change_retain)
			next_ud = main_frequency_setpoint;
		else if (up_edge)
			next_ud = (ud_up > {1'b0, dfrs_pkg::UPPER_MAX}) ? dfrs_pkg::UPPER_MAX : ud_up[15:0];
		else if (down_edge)
			next_ud = ({1'b0, ud_freq} <= {1'b0, lower_limit} + {1'b0, step}) ? lower_limit
				: ud_freq - step;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ud_freq <= dfrs_pkg::MAIN_RST;
		else
			ud_freq <= next_ud;
	end

	// Source and speed selection
	logic [2:0] code;
	logic [15:0] main_f, sel_f, next_freq;
	logic multi, next_rev;
	logic [39:0] meter_prod;
	logic [11:0] next_meter;
	always_comb begin
		main_f = main_frequency_source ? an_freq : ud_freq;
		// eight speeds only when assigned and mode 2
		multi = (speed_program_mode == dfrs_pkg::MODE_MULTI) && sel_assigned;
		// four speed mode uses two terminals
		if (multi)
			code = sync2[6:4];
		else if (speed_program_mode == dfrs_pkg::MODE_FOUR)
			code = {1'b0, sync2[5:4]};
		else
			code = '0;
		// code zero is the main frequency
		sel_f = (code == '0) ? main_f : preset_frequency[code - 3'h1];
		next_freq = sel_f;
		// direction from terminal in multi mode
		if (multi)
			next_rev = sync2[7];
		else
			next_rev = (main_frequency_source && code == '0 && an_rev) ^ fwd_rev;
		// meter scaled by gain, full scale at top frequency with gain 1000
		meter_prod = {24'h0, next_freq} * {30'h0, meter_output_gain} * {28'h0, dfrs_pkg::ADC_FULL}
			/ dfrs_pkg::METER_DEN;
		next_meter = meter_prod[11:0];
	end

	// APB read data
	logic [31:0] rd;
	always_comb begin
		rd = '0;
		unique case (paddr)
			dfrs_pkg::A_CFG: rd = {19'h0, cfg};
			dfrs_pkg::A_LOWER: rd = {16'h0, lower_point_frequency};
			dfrs_pkg::A_UPPER: rd = {16'h0, upper_point_frequency};
			dfrs_pkg::A_GAIN: rd = {22'h0, meter_output_gain};
			dfrs_pkg::A_FILT: rd = {26'h0, analog_filter_constant};
			dfrs_pkg::A_MAIN: rd = {16'h0, main_frequency_setpoint};
			dfrs_pkg::A_LIMIT: rd = {16'h0, lower_limit};
			dfrs_pkg::A_STATUS: rd = {13'h0, type_invalid, ramp_external, dir_reverse, freq_cmd};
			default: rd = hit ? {16'h0, preset_frequency[pidx]} : '0;
		endcase
	end

	// Output and bus flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_cmd <= '0;
			dir_reverse <= 1'b0;
			ramp_sel <= '0;
			ramp_external <= 1'b0;
			meter_out <= '0;
			type_invalid <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			freq_cmd <= next_freq;
			dir_reverse <= next_rev;
			ramp_sel <= multi ? sync2[9:8] : '0;
			ramp_external <= multi;
			meter_out <= next_meter;
			type_invalid <= in_bad;
			// Zero wait: ready in the first access cycle
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			prdata <= (psel & ~penable & ~pwrite) ? rd : prdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready not one cycle");
	type_bad_a: assert property (analog_input_type > 3'h4 |=> type_invalid
		&& (freq_cmd == '0 || !$past(main_frequency_source) || $past(code) != '0))
		else $error("invalid type not flagged");
	stack_full_a: assert property (analog_input_type == 3'h4 && filt[0] == 12'hfff
		&& filt[1] == 12'hfff && main_frequency_source && !multi && code == '0
		|=> freq_cmd == 16'h1388)
		else $error("stacked full scale wrong");
	gain_clamp_a: assert property (wr_en && paddr == dfrs_pkg::A_GAIN && pwdata[9:0] > 10'h3e8
		|=> meter_output_gain == 10'h3e8)
		else $error("gain not clamped");
	fine_step_a: assert property (up_edge && updown_step_size && ud_freq < dfrs_pkg::UPPER_MAX
		&& !run_fall && !wr_en |=> ud_freq == $past(ud_freq) + 16'h0001)
		else $error("fine step wrong");
	down_floor_a: assert property (down_edge && !run_fall && !up_edge && !wr_en
		|=> ud_freq >= $past(lower_limit))
		else $error("down passed limit");
	stop_drop_a: assert property (run_fall && !updown_change_retain && !wr_en
		|=> ud_freq == $past(main_frequency_setpoint))
		else $error("change kept at stop");
	preset_pick_a: assert property (multi && code == 3'h3 |=> freq_cmd == $past(sel_f)
		&& ramp_external)
		else $error("preset not selected");
	no_rev_a: assert property (!negative_bias_reverse_enable && !multi && !fwd_rev
		|=> !dir_reverse)
		else $error("reverse without permission");
	stack_c: cover property (analog_input_type == 3'h4 && main_frequency_source);
	multi_c: cover property (multi && code == 3'h7);
	retain_c: cover property (run_fall && updown_change_retain);
endmodule
`default_nettype wire

// ---- tb/dfrs_field.sv ----
// Purpose: Field side of the block: analog sources, switch terminals, panel keys
// Assumes: Every level changes just after a rising pclk edge
// Notes: Keys are held like a slow hand, so edge detection is exercised in earnest
`timescale 1ns/1ps
`default_nettype none
module dfrs_field (
	// Clock
	input wire logic pclk,
	// Analog sources
	output logic [11:0] volt_sample,
	output logic [11:0] curr_sample,
	// Switch terminals and keys
	output logic fwd_rev_pin,
	output logic run_pin,
	output logic up_key_pin,
	output logic down_key_pin,
	output logic [2:0] speed_sel_pin,
	output logic ext_dir_pin,
	output logic [1:0] ext_ramp_pin
);
	// Quiet field at power-up
	initial begin
		{volt_sample, curr_sample, fwd_rev_pin, run_pin} = '0;
		{up_key_pin, down_key_pin, speed_sel_pin, ext_dir_pin, ext_ramp_pin} = '0;
	end
	// One key stroke; the pause keeps strokes apart for the synchronisers
	task automatic press(input bit up, input int hold);
		@(posedge pclk);
		if (up) up_key_pin <= 1'b1;
		else down_key_pin <= 1'b1;
		repeat (hold) @(posedge pclk);
		up_key_pin <= 1'b0;
		down_key_pin <= 1'b0;
		repeat (hold) @(posedge pclk);
	endtask
	// Analog source levels
	task automatic analog(input logic [11:0] v, input logic [11:0] c);
		@(posedge pclk);
		volt_sample <= v;
		curr_sample <= c;
	endtask
	// Terminal levels
	task automatic terminals(input logic fr, input logic run, input logic [2:0] sel,
		input logic dir, input logic [1:0] ramp);
		@(posedge pclk);
		fwd_rev_pin <= fr;
		run_pin <= run;
		speed_sel_pin <= sel;
		ext_dir_pin <= dir;
		ext_ramp_pin <= ramp;
	endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the frequency reference select block
// Assumes: APB answers wait-free; outputs settle within six cycles of a cause
// Notes: Register model in ints; analog checks use curve end points and one stacked midpoint
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// Clock, reset and bus
	logic pclk;
	logic presetn;
	logic [7:0] paddr;
	logic psel, penable, pwrite;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	// Field side
	logic [11:0] volt_sample, curr_sample;
	logic fwd_rev_pin, run_pin, up_key_pin, down_key_pin, ext_dir_pin;
	logic [2:0] speed_sel_pin;
	logic [1:0] ext_ramp_pin, ramp_sel;
	// Command outputs
	logic [15:0] freq_cmd;
	logic [11:0] meter_out;
	logic dir_reverse, ramp_external, type_invalid;
	// Model state, indexed by word offset
	int regs [15] = '{0, 0, 5000, 1000, 20, 0, 0, 0, 1500, 2000, 2500, 3000, 3500, 4000, 50};
	int m_ud;
	int errors;
	int checks_done;
	int cycles;
	int r;
	logic [31:0] rd;
	logic err;

	dfrs_top dfrs_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .volt_sample(volt_sample),
		.curr_sample(curr_sample), .fwd_rev_pin(fwd_rev_pin), .run_pin(run_pin),
		.up_key_pin(up_key_pin), .down_key_pin(down_key_pin),
		.speed_sel_pin(speed_sel_pin), .ext_dir_pin(ext_dir_pin),
		.ext_ramp_pin(ext_ramp_pin), .freq_cmd(freq_cmd), .dir_reverse(dir_reverse),
		.ramp_sel(ramp_sel), .ramp_external(ramp_external), .meter_out(meter_out),
		.type_invalid(type_invalid));
	dfrs_field dfrs_field_inst (.pclk(pclk), .volt_sample(volt_sample),
		.curr_sample(curr_sample), .fwd_rev_pin(fwd_rev_pin), .run_pin(run_pin),
		.up_key_pin(up_key_pin), .down_key_pin(down_key_pin),
		.speed_sel_pin(speed_sel_pin), .ext_dir_pin(ext_dir_pin),
		.ext_ramp_pin(ext_ramp_pin));

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end
	// Counted comparison
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// One APB transfer; request held until pready is sampled high
	// Only the hang guard ends a wait that never sees pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Clamp as the register limits dictate
	function automatic int clampv(int i, int v);
		int lim [15] = '{32'h1fff, 40000, 60000, 1000, 50, 60000, 60000, 0,
			40000, 40000, 40000, 40000, 40000, 40000, 40000};
		return v > lim[i] ? lim[i] : v;
	endfunction
	// Write through the bus and the model; main setpoint reloads the working value
	task automatic wr(input int i, input int v);
		apb(1'b1, 8'(i * 4), 32'(v));
		regs[i] = clampv(i, v);
		if (i == 5) m_ud = regs[5];
		repeat (6) @(posedge pclk);
	endtask
	// Expected frequency outside the analog path
	function automatic int ref_freq(int sel);
		if (((regs[0] >> 8) & 7) == 2 && regs[0][12] && sel != 0) return regs[7 + sel];
		return m_ud;
	endfunction
	// Frequency, direction and meter against the model
	task automatic out_chk(input int f, input logic d);
		longint m;
		m = longint'(f) * regs[3] * 4095 / 60000000;
		check("freq_cmd", 32'(freq_cmd), 32'(f));
		check("dir_reverse", 32'(dir_reverse), 32'(d));
		check("meter_out", 32'(meter_out), 32'(m));
	endtask
	// Key stroke, then the model follows; down stops at the limit
	task automatic key(input bit up);
		int s;
		s = regs[0][7] ? 1 : 10;
		dfrs_field_inst.press(up, 4);
		repeat (6) @(posedge pclk);
		if (up) m_ud += s;
		else m_ud = (m_ud - s < regs[6]) ? regs[6] : m_ud - s;
		out_chk(m_ud, 1'b0);
	endtask
	// Analog stimulus then expected output
	task automatic ana(input int v, input int c, input int f, input logic d);
		dfrs_field_inst.analog(12'(v), 12'(c));
		repeat (6) @(posedge pclk);
		out_chk(f, d);
	endtask

	initial begin
		{paddr, psel, penable, pwrite, pwdata} = '0;
		presetn = 1'b0;
		void'($urandom(41957));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, then clamping of over-range writes
		for (int i = 0; i < 15; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			check("reset value", rd, 32'(regs[i]));
		end
		for (int i = 1; i < 5; i++) begin
			wr(i, 32'hffff);
			apb(1'b0, 8'(i * 4), 32'h0);
			check("clamped value", rd, 32'(regs[i]));
		end
		// Unmapped and unaligned places refuse
		apb(1'b0, 8'h3c, 32'h0);
		check("unmapped error", 32'(err), 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, 8'h05, 32'h1);
		check("unaligned error", 32'(err), 32'h1);
		// Every input type code
		for (int t = 0; t < 8; t++) begin
			wr(0, t);
			check("type_invalid", 32'(type_invalid), 32'(t > 4));
			apb(1'b0, 8'h1c, 32'h0);
			check("status flag", 32'(rd[18]), 32'(t > 4));
		end
		// Stored setpoint with random gain, then keys while running
		wr(0, 0);
		wr(3, $urandom_range(1000));
		wr(5, $urandom_range(30000, 2000));
		out_chk(m_ud, 1'b0);
		dfrs_field_inst.terminals(1'b0, 1'b1, 3'h0, 1'b0, 2'h0);
		key(1'b1);
		wr(0, 32'h80);
		key(1'b1);
		wr(6, m_ud);
		key(1'b0);
		wr(6, 0);
		key(1'b0);
		// Stop discards, then with retention keeps
		dfrs_field_inst.terminals(1'b0, 1'b0, 3'h0, 1'b0, 2'h0);
		repeat (6) @(posedge pclk);
		m_ud = regs[5];
		out_chk(m_ud, 1'b0);
		wr(0, 32'hc0);
		dfrs_field_inst.terminals(1'b0, 1'b1, 3'h0, 1'b0, 2'h0);
		key(1'b1);
		dfrs_field_inst.terminals(1'b0, 1'b0, 3'h0, 1'b0, 2'h0);
		repeat (6) @(posedge pclk);
		out_chk(m_ud, 1'b0);
		// Every select code, terminals giving direction and ramp, main step too
		wr(0, 32'h1200);
		for (int s = 0; s < 8; s++) begin
			r = $urandom_range(7);
			dfrs_field_inst.terminals(1'b0, 1'b0, 3'(s), r[2], r[1:0]);
			repeat (6) @(posedge pclk);
			out_chk(ref_freq(s), r[2]);
			check("ramp_sel", 32'(ramp_sel), 32'(r[1:0]));
			check("ramp_external", 32'(ramp_external), 32'h1);
		end
		// Without terminal assignment in mode 2, the main frequency rules
		wr(0, 32'h200);
		out_chk(m_ud, 1'b0);
		// Four speed mode reads terminals 1 and 2 only: select 7 gives preset 3
		wr(0, 32'h100);
		out_chk(regs[10], 1'b0);
		wr(0, 32'h0);
		check("ramp_external", 32'(ramp_external), 32'h0);
		// Analog curve end points, unfiltered
		dfrs_field_inst.terminals(1'b0, 1'b0, 3'h0, 1'b0, 2'h0);
		wr(4, 0);
		wr(0, 32'h800);
		ana(12'hfff, 0, regs[2], 1'b0);
		wr(1, 1000);
		wr(2, 3000);
		ana(12'hfff, 0, 3000, 1'b0);
		ana(0, 0, 1000, 1'b0);
		wr(0, 32'h801);
		ana(12'h7ff, 0, 3000, 1'b0);
		wr(0, 32'h803);
		ana(0, 12'h333, 1000, 1'b0);
		ana(0, 12'hfff, 3000, 1'b0);
		wr(0, 32'h804);
		ana(12'hfff, 12'hfff, 5000, 1'b0);
		ana(12'hfff, 0, 2500, 1'b0);
		ana(0, 0, 0, 1'b0);
		// Negative bias without and with permission, then the terminal flips it
		wr(0, 32'h818);
		ana(12'hfff, 0, 0, 1'b0);
		wr(0, 32'h838);
		ana(12'hfff, 0, 3000, 1'b1);
		dfrs_field_inst.terminals(1'b1, 1'b0, 3'h0, 1'b0, 2'h0);
		ana(12'hfff, 0, 3000, 1'b0);
		// Heavy filtering lags a step that no filtering passes at once
		dfrs_field_inst.terminals(1'b0, 1'b0, 3'h0, 1'b0, 2'h0);
		wr(0, 32'h800);
		ana(0, 0, 1000, 1'b0);
		wr(4, 50);
		dfrs_field_inst.analog(12'hfff, 12'h0);
		repeat (50) @(posedge pclk);
		check("filter lag", 32'(freq_cmd < 16'(3000)), 32'h1);
		wr(4, 0);
		out_chk(3000, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
